// ### logic/dacc_top.sv
/*
 * Conversion control, result latch and output enable of a dual converter.
 * Assumes host pins are asynchronous; analog results arrive as parallel words.
 */
`timescale 1ns/1ps
module dacc_top
    import dacc_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int ACQ_CYCLES = ACQ_CYC
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic CONVERT_START_N_I,
    input wire logic CS_N_I,
    input wire logic RD_N_I,
    input wire logic POWER_DOWN_IN_I,
    input wire logic IMPULSE_MODE_I,
    input wire logic SERIAL_PARALLEL_SEL_I,
    input wire logic CHAN_ORDER_SEL_I,
    input wire logic SCLK_I,
    input wire logic [RES_BITS-1:0] RESULT_A_I,
    input wire logic [RES_BITS-1:0] RESULT_B_I,
    output logic BUSY_O,
    output logic EOC_N_O,
    output logic HOLD_O,
    output logic POWERED_DOWN_O,
    output logic [RES_BITS-1:0] PAR_DATA_O,
    output logic PAR_OE_O,
    output logic SDOUT_O,
    output logic SDOUT_OE_O
);
    localparam logic [CNT_W-1:0] CONV_LAST = CONV_CYCLES[CNT_W-1:0] - CNT_ONE;
    localparam logic [CNT_W-1:0] ACQ_LAST = ACQ_CYCLES[CNT_W-1:0] - CNT_ONE;

    //////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every host pin; stage 1 read only by stage 2
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic cnv_d;
    logic sclk_d;
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            // idle levels, so no false power-down or clock edge after reset
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end
        else
        begin
            sync1 <= {CONVERT_START_N_I, CS_N_I, RD_N_I, POWER_DOWN_IN_I,
                      IMPULSE_MODE_I, SCLK_I};
            sync2 <= sync1;
        end
    end
    wire cnv_n = sync2[5];
    wire cs_n = sync2[4];
    wire rd_n = sync2[3];
    wire pwr_dn = sync2[2];
    wire impulse = sync2[1];
    wire sclk = sync2[0];
    logic ser_sel_q;
    logic ser_sel;
    logic order_q;
    logic order;
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            ser_sel_q <= 1'b0;
            ser_sel <= 1'b0;
            order_q <= 1'b0;
            order <= 1'b0;
        end
        else
        begin
            ser_sel_q <= SERIAL_PARALLEL_SEL_I;
            ser_sel <= ser_sel_q;
            order_q <= CHAN_ORDER_SEL_I;
            order <= order_q;
        end
    end

    //////////////////////////////////////////////////////////////////
    // start decode: edge, or held low at end of acquisition in impulse mode
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            cnv_d <= 1'b1;
            sclk_d <= 1'b0;
        end
        else
        begin
            cnv_d <= cnv_n;
            sclk_d <= sclk;
        end
    end
    dacc_state_e state;
    dacc_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] eoc_cnt;
    logic [RES_BITS-1:0] res_a;
    logic [RES_BITS-1:0] res_b;
    logic [SR_BITS-1:0] par_word;
    wire cnv_fall = cnv_d & ~cnv_n; // see RULE_08
    wire acq_done = (state == DACC_ACQ) && (cnt == ACQ_LAST);
    wire held_start = impulse & ~cnv_n & acq_done; // see RULE_09
    wire start_ok = ~pwr_dn & ((state == DACC_IDLE & cnv_fall) | held_start); // see RULE_07
    wire chan_done = (state == DACC_CONV_A || state == DACC_CONV_B) && (cnt == CONV_LAST);
    wire latch = (state == DACC_CONV_B) && (cnt == CONV_LAST);

    //////////////////////////////////////////////////////////////////
    // sequencer; acquisition follows each cycle, edges during it are lost
    always_comb
    begin
        next_state = state;
        unique case (state)
            DACC_IDLE: if (start_ok) next_state = DACC_CONV_A;
            DACC_CONV_A: if (chan_done) next_state = DACC_CONV_B; // see RULE_12
            DACC_CONV_B: if (chan_done) next_state = DACC_ACQ;
            DACC_ACQ:
            begin
                if (start_ok)
                    next_state = DACC_CONV_A;
                else if (acq_done)
                    next_state = DACC_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            state <= DACC_IDLE; // see RULE_06
        else
            state <= next_state;
    end
    // one counter serves both conversion slots and acquisition
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            cnt <= CNT_ZERO;
        else if (state != next_state || state == DACC_IDLE)
            cnt <= CNT_ZERO;
        else
            cnt <= cnt + CNT_ONE;
    end

    //////////////////////////////////////////////////////////////////
    // end-of-conversion strobe, low for EOC_CYC cycles per channel
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            eoc_cnt <= CNT_ZERO;
        else if (chan_done)
            eoc_cnt <= EOC_CYC[CNT_W-1:0]; // see RULE_03
        else if (eoc_cnt != CNT_ZERO)
            eoc_cnt <= eoc_cnt - CNT_ONE;
    end
    assign EOC_N_O = (eoc_cnt == CNT_ZERO);
    // busy covers both slots; falls with the latch, in the same cycle the second strobe starts
    assign BUSY_O = (state == DACC_CONV_A) || (state == DACC_CONV_B); // see RULE_01
    assign HOLD_O = BUSY_O; // see RULE_08
    assign POWERED_DOWN_O = pwr_dn && (state == DACC_IDLE); // see RULE_07

    //////////////////////////////////////////////////////////////////
    // result latch: both channels latched together at the second slot end, at busy fall
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            res_a <= '0;
            res_b <= '0;
        end
        else if (latch)
        begin
            res_a <= RESULT_A_I; // see RULE_02
            res_b <= RESULT_B_I;
        end
    end
    assign par_word = order ? {RESULT_B_I, RESULT_A_I} : {RESULT_A_I, RESULT_B_I};

    //////////////////////////////////////////////////////////////////
    // output enable and serial clock gate
    wire read_en = ~cs_n & ~rd_n; // see RULE_04
    wire sclk_rise = ~cs_n & sclk & ~sclk_d; // see RULE_05
    logic [BIT_CNT_W-1:0] bit_cnt;
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            bit_cnt <= BIT_ZERO;
        else if (latch)
            bit_cnt <= BIT_ZERO;
        else if (sclk_rise && ser_sel)
            bit_cnt <= bit_cnt + BIT_ONE;
    end
    dacc_ser_if ser ();
    assign ser.load = latch;
    assign ser.data = par_word; // see RULE_10
    assign ser.shift_edge = sclk_rise & ser_sel;
    dacc_shifter u_shifter (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .ser(ser.shifter)
    );
    // parallel bus shows channel a by default, b when exactly one of order select high and serial bit count odd holds
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            PAR_DATA_O <= '0;
        else
            PAR_DATA_O <= (order ^ bit_cnt[0]) ? res_b : res_a;
    end
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            SDOUT_O <= 1'b0;
        else
            SDOUT_O <= ser.sdo;
    end
    assign PAR_OE_O = read_en & ~ser_sel; // see RULE_11
    assign SDOUT_OE_O = read_en & ser_sel; // see RULE_11

    //////////////////////////////////////////////////////////////////
    // checks
    sequence s_second_slot_end;
        (state == DACC_CONV_B) && (cnt == CONV_LAST);
    endsequence
    AST_BUSY_START: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_01
        start_ok |=> BUSY_O) else $error("busy not raised at start");
    AST_BUSY_FALL: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_12
        s_second_slot_end |=> !BUSY_O && !EOC_N_O) else $error("busy fall wrong");
    AST_EOC_ONCE: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_03
        $rose(BUSY_O) |-> EOC_N_O) else $error("eoc low at start");
    AST_OE: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_04
        (PAR_OE_O || SDOUT_OE_O) |-> (!cs_n && !rd_n)) else $error("bus enabled unread");
    AST_SCLK_GATE: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_05
        cs_n |-> !ser.shift_edge) else $error("shift while deselected");
    AST_POWER_DOWN: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_07
        (pwr_dn && state == DACC_IDLE) |=> state == DACC_IDLE) else $error("start in powerdown");
    AST_EDGE: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_08
        (state == DACC_IDLE && cnv_fall && !pwr_dn) |=> HOLD_O) else $error("edge not taken");
    AST_HELD: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_09
        (acq_done && impulse && !cnv_n && !pwr_dn) |=> state == DACC_CONV_A)
        else $error("held start missed");
    AST_SEL: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // see RULE_11
        !(PAR_OE_O && SDOUT_OE_O)) else $error("both ports enabled");
endmodule

// ### logic/dacc_pkg.sv
/*
 * Constants, state type and sizes shared by the dual-channel conversion-control logic.
 * Assumes a single 200 MHz clock and an asynchronous active-high reset.
 */
// What this block does
// RULE_01: busy rises at conversion start, stays high until both results are latched.
// RULE_02: busy falling edge tells the host that fresh results are ready.
// RULE_03: end-of-conversion pulses low once per channel conversion.
// RULE_04: output bus enabled only while chip select and read enable are both low.
// RULE_05: external serial clock is gated by chip select; edges ignored when deselected.
// RULE_06: reset high returns to idle and aborts any running conversion.
// RULE_07: power-down lets the current conversion finish, then blocks new starts.
// RULE_08: falling convert-start edge seen in idle puts hold on and starts a conversion.
// RULE_09: low-power mode starts at acquisition end if convert-start is still low.
// RULE_10: both results sit in one shift register, shifted msb first, order selectable.
// RULE_11: serial/parallel select low gives parallel bus, high gives serial port.
// RULE_12: channels convert one after another; busy falls as the second strobe starts.
package dacc_pkg;
    localparam int RES_BITS = 16;
    localparam int SR_BITS = 2 * RES_BITS;
    localparam int CLK_PERIOD_PS = 5000;
    // conversion time per channel and acquisition time, nanoseconds
    localparam int CONV_TIME_NS = 800;
    localparam int ACQ_TIME_NS = 250;
    localparam int EOC_TIME_NS = 10;
    localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACQ_CYC = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EOC_CYC = (EOC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
    localparam int BIT_CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    localparam logic [SR_BITS-1:0] SR_RESET = 32'h0000_0000;
    localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 6'h00;
    localparam logic [BIT_CNT_W-1:0] BIT_ONE = 6'h01;
    // idle pin levels {start, select, read, power-down, low-power mode, serial clock}
    localparam logic [5:0] SYNC_IDLE = 6'h38;
    // gray sequence: idle, conv a, conv b, acquire
    typedef enum logic [1:0] {
        DACC_IDLE = 2'h0,
        DACC_CONV_A = 2'h1,
        DACC_CONV_B = 2'h3,
        DACC_ACQ = 2'h2
    } dacc_state_e;
endpackage

// ### logic/dacc_ser_if.sv
/*
 * Carrier between conversion control and the serial shifter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface dacc_ser_if;
    import dacc_pkg::*;
    logic load;
    logic [SR_BITS-1:0] data;
    logic shift_edge;
    logic sdo;
    modport ctrl (output load, output data, output shift_edge, input sdo);
    modport shifter (input load, input data, input shift_edge, output sdo);
endinterface

// ### logic/dacc_shifter.sv
/*
 * Result shift register, msb first, loaded on result latch.
 * Assumes shift_edge is a single-cycle synchronous pulse.
 */
`timescale 1ns/1ps
module dacc_shifter
    import dacc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    dacc_ser_if.shifter ser
);
    logic [SR_BITS-1:0] sr;
    //////////////////////////////////////////////////////////////////
    // load wins over shift so a fresh result is never half-shifted
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sr <= SR_RESET;
        else if (ser.load)
            sr <= ser.data; // see RULE_10
        else if (ser.shift_edge)
            sr <= {sr[SR_BITS-2:0], 1'b0}; // see RULE_10
    end
    assign ser.sdo = sr[SR_BITS-1];
endmodule

// ### test/dacc_host_model.sv
/*
 * Host-side model that drives the start, select, read and serial clock pins.
 * Assumes the bench calls its tasks and that all pins move at the falling clock edge.
 */
`timescale 1ns/1ps
module dacc_host_model
(
    input wire logic clk_i,
    output logic cnv_n_o,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic sclk_o
);
    // idle levels: deselected and serial clock parked low between frames
    initial
    begin
        cnv_n_o = 1'b1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        sclk_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // short low pulse, long enough to pass the two-flop synchroniser
    task start_pulse();
        @(negedge clk_i) cnv_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        cnv_n_o = 1'b1;
    endtask

    // level drive of the start pin, used for held-low starts
    task start_level(input logic lvl);
        @(negedge clk_i) cnv_n_o = lvl;
    endtask

    // both low to read
    task select(input logic cs_n, input logic rd_n);
        @(negedge clk_i);
        cs_n_o = cs_n;
        rd_n_o = rd_n;
    endtask

    // slow pulse: the device samples the clock, so each phase spans four cycles
    task sclk_pulse();
        @(negedge clk_i) sclk_o = 1'b1;
        repeat (4) @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// ### test/tb_dual_adc_conversion_control.sv
/*
 * Self-checking bench for the dual conversion control block.
 * Assumes shortened counts of 8 conversion and 4 acquisition cycles.
 */
`timescale 1ns/1ps
module tb_dual_adc_conversion_control;
    import dacc_pkg::*;
    localparam int CONV = 8;
    localparam int ACQ = 4;
    localparam logic [RES_BITS-1:0] VAL_A = 16'ha5c3;
    localparam logic [RES_BITS-1:0] VAL_B = 16'h3c96;
    logic clock, reset, pwr_dn, imp, spsel, order, cnv_n, cs_n, rd_n, sclk;
    logic busy, eoc_n, hold, pwd, par_oe, sdout, sdout_oe;
    logic [RES_BITS-1:0] par_data;
    int fails, tests_run;

    dacc_host_model host (.clk_i(clock), .cnv_n_o(cnv_n), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .sclk_o(sclk));
    dacc_top #(.CONV_CYCLES(CONV), .ACQ_CYCLES(ACQ)) uut (.CLOCK_I(clock), .RESET_I(reset),
        .CONVERT_START_N_I(cnv_n), .CS_N_I(cs_n), .RD_N_I(rd_n), .POWER_DOWN_IN_I(pwr_dn),
        .IMPULSE_MODE_I(imp), .SERIAL_PARALLEL_SEL_I(spsel), .CHAN_ORDER_SEL_I(order),
        .SCLK_I(sclk), .RESULT_A_I(VAL_A), .RESULT_B_I(VAL_B), .BUSY_O(busy),
        .EOC_N_O(eoc_n), .HOLD_O(hold), .POWERED_DOWN_O(pwd), .PAR_DATA_O(par_data),
        .PAR_OE_O(par_oe), .SDOUT_O(sdout), .SDOUT_OE_O(sdout_oe));

    // free-running 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // bounded wait for busy; the synchroniser adds a few cycles
    task wait_busy();
        int k;
        k = 0;
        while (busy !== 1'b1 && k < 12)
        begin
            @(negedge clock);
            k++;
        end
        check(busy, 1'b1);
        check(hold, 1'b1);
    endtask

    // counts busy cycles and falling end-of-conversion strobes, tail included
    task measure(output int n, output int e);
        logic prev;
        n = 0;
        e = 0;
        prev = 1'b1;
        while (busy === 1'b1 && n < 400)
        begin
            if (prev === 1'b1 && eoc_n === 1'b0) e++;
            prev = eoc_n;
            @(negedge clock);
            n++;
        end
        repeat (3)
        begin
            if (prev === 1'b1 && eoc_n === 1'b0) e++;
            prev = eoc_n;
            @(negedge clock);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task conv_normal();
        int n, e;
        host.start_pulse();
        wait_busy();
        measure(n, e);
        check(n, 2 * CONV);
        check(e, 2);
        check(e, 2);
        repeat (ACQ + 2) @(negedge clock);
    endtask

    // read after busy has fallen
    task par_read();
        spsel = 1'b0;
        order = 1'b0;
        repeat (2) @(negedge clock);
        check(par_oe, 1'b0);
        host.select(1'b0, 1'b0);
        repeat (2) @(negedge clock);
        check(par_oe, 1'b1);
        check(sdout_oe, 1'b0);
        check(par_data, VAL_A);
        order = 1'b1;
        repeat (3) @(negedge clock);
        check(par_data, VAL_B);
        host.select(1'b0, 1'b1);
        repeat (2) @(negedge clock);
        check(par_oe, 1'b0);
        host.select(1'b1, 1'b1);
        order = 1'b0;
    endtask

    // clock edges while deselected must not advance the register
    task ser_read();
        logic [SR_BITS-1:0] got;
        spsel = 1'b1;
        repeat (3) host.sclk_pulse();
        host.select(1'b0, 1'b0);
        repeat (2) @(negedge clock);
        check(sdout_oe, 1'b1);
        check(par_oe, 1'b0);
        for (int i = SR_BITS - 1; i >= 0; i--)
        begin
            got[i] = sdout;
            host.sclk_pulse();
        end
        check(got, {VAL_A, VAL_B});
        check(got[31:24], VAL_A[15:8]);
        host.select(1'b1, 1'b1);
        spsel = 1'b0;
    endtask

    task power_down();
        int n, e;
        host.start_pulse();
        wait_busy();
        pwr_dn = 1'b1;
        measure(n, e);
        check(e, 2);
        repeat (ACQ + 4) @(negedge clock);
        check(pwd, 1'b1);
        host.start_pulse();
        repeat (10) @(negedge clock);
        check(busy, 1'b0);
        pwr_dn = 1'b0;
        repeat (4) @(negedge clock);
    endtask

    task reset_abort();
        host.start_pulse();
        wait_busy();
        repeat (3) @(negedge clock);
        reset = 1'b1;
        @(negedge clock);
        check(busy, 1'b0);
        check(eoc_n, 1'b1);
        reset = 1'b0;
        repeat (CONV * 3) @(negedge clock);
        check(busy, 1'b0);
    endtask

    // held-low start retriggers once acquisition ends
    task impulse_retrigger();
        int n, e;
        imp = 1'b1;
        host.start_level(1'b0);
        wait_busy();
        measure(n, e);
        wait_busy();
        check(busy, 1'b1);
        host.start_level(1'b1);
        measure(n, e);
        check(e, 2);
        imp = 1'b0;
        repeat (ACQ + 2) @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset for eight cycles, then each scenario in turn
    initial
    begin
        fails = 0;
        tests_run = 0;
        reset = 1'b1;
        pwr_dn = 1'b0;
        imp = 1'b0;
        spsel = 1'b0;
        order = 1'b0;
        repeat (8) @(negedge clock);
        reset = 1'b0;
        repeat (2) @(negedge clock);
        conv_normal();
        par_read();
        ser_read();
        conv_normal();
        power_down();
        reset_abort();
        impulse_retrigger();
        wrap_up();
    end

    // whole run needs about 550 cycles; cut a hang well past that
    initial
    begin
        #50000;
        fails++;
        wrap_up();
    end
endmodule
